// >>> inc/wtc_pkg.sv
/*
 * Shared constants for the timeout guard: register map, field positions,
 * reset values, timing counts, the mode encoding and the period lookup.
 * Assumes a single 250 MHz system clock and a 32-bit APB register port.
 */
package wtc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses on a 12-bit APB address.
   localparam logic [11:0] ADDR_CONTROL_STATUS = 12'h000;
   localparam logic [11:0] ADDR_RESET_CAUSE    = 12'h004;
   localparam int          ADDR_W              = 12;

   // Control/status field positions.
   localparam int BIT_IRQ_FLAG     = 7;
   localparam int BIT_IRQ_ENABLE   = 6;
   localparam int BIT_PERIOD_MSB   = 5;
   localparam int BIT_UNLOCK       = 4;
   localparam int BIT_RESET_ENABLE = 3;
   localparam int BIT_PERIOD_2     = 2;
   localparam int BIT_PERIOD_0     = 0;

   // Reset-cause register field position.
   localparam int BIT_CAUSE_FLAG   = 3;

   // Reset values.
   localparam logic [3:0] PERIOD_RESET     = 4'h0;
   localparam logic       FUSE_RESET_VALUE = 1'b1;  // Unprogrammed until sampled.

   ////////////////////////////////////////////////////////////////////////////
   // Timing.
   localparam longint PCLK_HZ        = 250_000_000;
   localparam longint OSC_HZ         = 128_000;
   // Pclk cycles per oscillator cycle, rounded down.
   localparam int     OSC_DIV_CYCLES = int'(PCLK_HZ / OSC_HZ);
   // Cycles the change-unlock bit stays set after it is written.
   localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
   // Shortest period is two to this power oscillator cycles.
   localparam int     PERIOD_BASE_LOG2 = 11;
   // Last defined period code; higher codes are reserved.
   localparam logic [3:0] PERIOD_SEL_LAST = 4'h9;
   localparam int     COUNT_W = 22;

   ////////////////////////////////////////////////////////////////////////////
   // Operating mode, one-hot.
   typedef enum logic [3:0] {
      MODE_STOPPED   = 4'b0001,
      MODE_IRQ       = 4'b0010,
      MODE_RESET     = 4'b0100,
      MODE_IRQ_RESET = 4'b1000
   } wtc_mode_type;

   // Oscillator cycles of one period; reserved codes use the longest period.
   function automatic logic [COUNT_W-1:0] wtc_period_limit(input logic [3:0] sel,
                                                          input int base_log2);
      logic [3:0] eff;
      eff = (sel > PERIOD_SEL_LAST) ? PERIOD_SEL_LAST : sel;
      return COUNT_W'(64'h1 << (base_log2 + int'(eff)));
   endfunction

endpackage

// >>> inc/wtc_count_if.sv
/*
 * Carrier between the register/control logic and the period counter.
 * Assumes both ends run on pclk.
 */
`timescale 1ns/1ps
interface wtc_count_if;
   logic       restart;        // Restart the count from zero.
   logic       run;            // Count while high.
   logic [3:0] period_select;  // Period code.
   logic       timeout;        // One-cycle pulse at expiry.

   modport ctrl    (output restart, output run, output period_select, input timeout);
   modport counter (input restart, input run, input period_select, output timeout);
endinterface

// >>> src/wtc_counter.sv
/*
 * Period counter of the timeout guard: an oscillator-rate enable derived
 * from pclk and a count of oscillator ticks compared against the period.
 * Assumes the control side drives run, restart and period on pclk.
 */
`timescale 1ns/1ps
module wtc_counter
   import wtc_pkg::*;
#(
   parameter int OSC_DIV   = wtc_pkg::OSC_DIV_CYCLES,
   parameter int BASE_LOG2 = wtc_pkg::PERIOD_BASE_LOG2
)
(
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Control side
   wtc_count_if.counter      cnt
);

   logic [15:0]        div;
   logic               osc_tick;
   logic [COUNT_W-1:0] count;
   logic [COUNT_W-1:0] limit;
   logic               expire;

   ////////////////////////////////////////////////////////////////////////////
   // The oscillator is modelled as an enable on pclk, so the expiry event
   // and the restart meet in one domain and need no crossing.
   // single domain events
   assign osc_tick = (div == 16'(OSC_DIV - 1));
   assign limit    = wtc_period_limit(cnt.period_select, BASE_LOG2);
   // Compare with >= so a switch to a shorter period expires on the next oscillator tick.
   assign expire   = cnt.run && osc_tick && (count >= limit - COUNT_W'(1));

   // Oscillator divider, free running.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         div <= 16'h0000;
      else if (osc_tick)
         div <= 16'h0000;
      else
         div <= div + 16'h0001;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count <= '0;
      else if (cnt.restart || !cnt.run || expire)
         count <= '0;
      else if (osc_tick)
         count <= count + COUNT_W'(1);
   end

   // A restart in the expiry cycle wins, so no late timeout slips out.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt.timeout <= 1'b0;
      else
         cnt.timeout <= expire && !cnt.restart;
   end

endmodule // wtc_counter

// >>> src/wtc_timeout_guard.sv
/*
 * Timeout guard with interrupt, system reset and interrupt-then-reset modes,
 * a timed unlock for protected changes, an always-on fuse and a reset-cause
 * flag. Registers are reached over APB with zero wait states.
 * Assumes presetn is the power-on reset only: a guard reset is requested on
 * system_reset_pulse and the block re-initialises itself at that moment.
 * Assumes counter_restart, irq_vector_ack and cpu_global_irq_enable come from
 * CPU logic on pclk; the fuse level comes from outside and is synchronised.
 */
// The implementer's own choices: the address map and the APB interface to the registers.
// Summary of operation
// - Timeout in an interrupt mode sets the interrupt flag, bit 7.
// - Vector execution or writing one clears the interrupt flag.
// - Interrupt requested only when flag, enable and CPU global enable all set.
// - Reset and interrupt enables select stopped, interrupt, reset or combined mode.
// - Programmed fuse forces reset mode, reset enable one, interrupt enable zero.
// - Combined mode: first timeout sets flag; vector clears flag and enable.
// - Combined mode: second timeout with flag still pending gives system reset.
// - Clearing reset enable or changing period needs change-unlock set.
// - Change-unlock clears itself four clock cycles after being written.
// - Reset enable forced to one while the reset-cause flag is set.
// - Guard reset sets the cause flag; power-on or writing zero clears it.
// - Four-bit period select sits in bits 5, 2, 1, 0, bit 5 most significant.
// - Codes 0 to 9 give 2048 to 1048576 oscillator cycles, doubling.
// - Counter counts oscillator cycles; restart instruction zeroes it.
// - After a guard reset the block stays enabled in reset mode.
// - Reset leaves flag, enable, unlock and period zero; reset enable follows cause.
`timescale 1ns/1ps
module wtc_timeout_guard
   import wtc_pkg::*;
#(
   parameter int OSC_DIV   = wtc_pkg::OSC_DIV_CYCLES,
   parameter int BASE_LOG2 = wtc_pkg::PERIOD_BASE_LOG2
)
(
   // Clock and reset
   input  wire logic                     pclk,
   input  wire logic                     presetn,
   // APB slave
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [wtc_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]              pwdata,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   // CPU side
   input  wire logic                     counter_restart,
   input  wire logic                     irq_vector_ack,
   input  wire logic                     cpu_global_irq_enable,
   output logic                          timeout_irq,
   output logic                          system_reset_pulse,
   // Fuse, programmed when low
   input  wire logic                     always_on_fuse_n
);

   import wtc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.
   wtc_count_if cnt ();

   logic         irq_flag;
   logic         irq_enable;
   logic         unlock;
   logic [2:0]   unlock_cnt;
   logic         reset_enable;
   logic [3:0]   period_select;
   logic         cause_flag;
   logic [2:0]   fuse_sync;
   logic         fuse_n;

   logic         next_irq_flag;
   logic         next_irq_enable;
   logic         next_unlock;
   logic [2:0]   next_unlock_cnt;
   logic         next_reset_enable;
   logic [3:0]   next_period_select;
   logic         next_cause_flag;

   logic         set_irq_flag;
   logic         guard_reset;
   wtc_mode_type mode;

   ////////////////////////////////////////////////////////////////////////////
   // APB decode. The slave answers in the access phase with no wait states.
   wire          access      = psel && penable;
   wire          sel_csr     = (paddr == ADDR_CONTROL_STATUS);
   wire          sel_cause   = (paddr == ADDR_RESET_CAUSE);
   wire          hit         = sel_csr || sel_cause;
   wire          wr_csr      = access && pwrite && sel_csr;
   wire          wr_cause    = access && pwrite && sel_cause;

   // Field views of the write data.
   wire          wd_irq_flag = pwdata[BIT_IRQ_FLAG];
   wire          wd_irq_en   = pwdata[BIT_IRQ_ENABLE];
   wire          wd_unlock   = pwdata[BIT_UNLOCK];
   wire          wd_reset_en = pwdata[BIT_RESET_ENABLE];
   wire [3:0]    wd_period   = {pwdata[BIT_PERIOD_MSB], pwdata[BIT_PERIOD_2:BIT_PERIOD_0]};
   wire          wd_cause    = pwdata[BIT_CAUSE_FLAG];

   assign pready  = 1'b1;
   // Unmapped addresses take the transfer but flag an error.
   assign pslverr = access && !hit;

   ////////////////////////////////////////////////////////////////////////////
   // Fuse synchroniser: the level only moves once stages two and three agree.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fuse_sync <= {3{FUSE_RESET_VALUE}};
      else
         fuse_sync <= {fuse_sync[1:0], always_on_fuse_n};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         fuse_n <= FUSE_RESET_VALUE;
      else if (fuse_sync[1] == fuse_sync[2])
         fuse_n <= fuse_sync[2];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Effective enables as software sees and the mode decode uses them.
   wire          fuse_prog     = !fuse_n;
   wire          reset_en_eff  = reset_enable || cause_flag || fuse_prog;
   wire          irq_en_eff    = irq_enable && !fuse_prog;

   assign mode = fuse_prog                    ? MODE_RESET :
                 (reset_en_eff && irq_en_eff) ? MODE_IRQ_RESET :
                 reset_en_eff                 ? MODE_RESET :
                 irq_en_eff                   ? MODE_IRQ :
                                                MODE_STOPPED;

   ////////////////////////////////////////////////////////////////////////////
   // Timeout action per mode.
   always_comb
   begin
      set_irq_flag = 1'b0;
      guard_reset  = 1'b0;
      case (mode)
         MODE_IRQ:
            set_irq_flag = cnt.timeout;
         MODE_RESET:
            guard_reset  = cnt.timeout;
         MODE_IRQ_RESET:
         begin
            guard_reset  = cnt.timeout && irq_flag;
            set_irq_flag = cnt.timeout && !irq_flag;
         end
         default:
         begin
            set_irq_flag = 1'b0;
            guard_reset  = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt flag and enable. A new timeout wins over a clear in the
   // same cycle; a guard reset re-initialises both.
   always_comb
   begin
      next_irq_flag = irq_flag;
      if ((wr_csr && wd_irq_flag) || irq_vector_ack)
         next_irq_flag = 1'b0;
      if (set_irq_flag)
         next_irq_flag = 1'b1;
      if (guard_reset)
         next_irq_flag = 1'b0;

      next_irq_enable = irq_enable;
      if (wr_csr)
         next_irq_enable = wd_irq_en;
      if (irq_vector_ack && (mode == MODE_IRQ_RESET))
         next_irq_enable = 1'b0;
      if (fuse_prog || guard_reset)
         next_irq_enable = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Change-unlock window. Rewriting the bit restarts the window.
   always_comb
   begin
      next_unlock     = unlock;
      next_unlock_cnt = unlock_cnt;
      if (guard_reset)
      begin
         next_unlock     = 1'b0;
         next_unlock_cnt = 3'h0;
      end
      else if (wr_csr && wd_unlock)
      begin
         next_unlock     = 1'b1;
         next_unlock_cnt = UNLOCK_CYCLES;
      end
      else if (unlock)
      begin
         next_unlock_cnt = unlock_cnt - 3'h1;
         if (unlock_cnt == 3'h1)
            next_unlock = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Protected fields. Setting the reset enable is always allowed; clearing
   // it needs the window open, no pending cause and an unprogrammed fuse.
   always_comb
   begin
      next_reset_enable = reset_enable;
      if (wr_csr && wd_reset_en)
         next_reset_enable = 1'b1;
      else if (wr_csr && unlock && !cause_flag && !fuse_prog)
         next_reset_enable = 1'b0;
      if (guard_reset)
         next_reset_enable = 1'b1;

      next_period_select = period_select;
      if (wr_csr && unlock)
         next_period_select = wd_period;
      if (guard_reset)
         next_period_select = PERIOD_RESET;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset-cause flag: a guard reset in the same cycle beats a clear.
   always_comb
   begin
      next_cause_flag = cause_flag;
      if (wr_cause && !wd_cause)
         next_cause_flag = 1'b0;
      if (guard_reset)
         next_cause_flag = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // State registers.
   // reset values
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_flag      <= 1'b0;
         irq_enable    <= 1'b0;
         unlock        <= 1'b0;
         unlock_cnt    <= 3'h0;
         reset_enable  <= 1'b0;
         period_select <= PERIOD_RESET;
         cause_flag    <= 1'b0;
      end
      else
      begin
         irq_flag      <= next_irq_flag;
         irq_enable    <= next_irq_enable;
         unlock        <= next_unlock;
         unlock_cnt    <= next_unlock_cnt;
         reset_enable  <= next_reset_enable;
         period_select <= next_period_select;
         cause_flag    <= next_cause_flag;
      end
   end

   // Guard reset request, one pclk wide.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         system_reset_pulse <= 1'b0;
      else
         system_reset_pulse <= guard_reset;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data is captured in the setup phase so it comes from a flop.
   wire [7:0] csr_view   = {irq_flag, irq_en_eff, period_select[3], unlock,
                            reset_en_eff, period_select[2:0]};
   wire [7:0] cause_view = {4'h0, cause_flag, 3'h0};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (psel && !penable)
      begin
         if (sel_csr)
            prdata <= {24'h000000, csr_view};
         else if (sel_cause)
            prdata <= {24'h000000, cause_view};
         else
            prdata <= 32'h00000000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt request gating
   assign timeout_irq = irq_flag && irq_en_eff && cpu_global_irq_enable;

   // Counter control. A guard reset also restarts the count.
   // restart instruction
   assign cnt.restart       = counter_restart || guard_reset;
   assign cnt.run           = (mode != MODE_STOPPED);
   assign cnt.period_select = period_select;

   wtc_counter #(
      .OSC_DIV   (OSC_DIV),
      .BASE_LOG2 (BASE_LOG2)
   ) u_counter (
      .pclk    (pclk),
      .presetn (presetn),
      .cnt     (cnt)
   );

endmodule // wtc_timeout_guard

// >>> dv/wtc_timeout_guard_checker.sv
/* Port checker for the timeout guard.
   Assumes it is bound into the guard and sees only its top-level ports. */
`timescale 1ns/1ps
module wtc_timeout_guard_checker
   import wtc_pkg::*;
#(
   parameter int OSC_DIV   = 2,
   parameter int BASE_LOG2 = 2
)
(
   // Clock and reset
   input wire logic              pclk,
   input wire logic              presetn,
   // APB slave side
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       prdata,
   input wire logic              pslverr,
   // CPU side
   input wire logic              counter_restart,
   input wire logic              irq_vector_ack,
   input wire logic              cpu_global_irq_enable,
   input wire logic              timeout_irq,
   input wire logic              system_reset_pulse,
   // Fuse
   input wire logic              always_on_fuse_n
);
   ////////////////////////////////////////////////////////////////////////////
   // Access decode; the unmapped check needs both mapped words.
   logic acc;
   logic mapped;
   assign acc    = psel && penable;
   assign mapped = (paddr == ADDR_CONTROL_STATUS) || (paddr == ADDR_RESET_CAUSE);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   ////////////////////////////////////////////////////////////////////////////
   // The interrupt line is gated by the CPU global enable at all times.
   chk_irq_needs_global: assert property (
      timeout_irq |-> cpu_global_irq_enable) else $error("irq without global enable");
   chk_irq_drop_global: assert property (
      $fell(cpu_global_irq_enable) |-> !timeout_irq) else $error("irq stayed after disable");
   // A taken vector removes the request on the next cycle.
   chk_ack_clears_irq: assert property (
      timeout_irq && irq_vector_ack |=> !timeout_irq) else $error("irq not cleared by ack");
   // Pulses are one cycle and never closer than the shortest period.
   chk_pulse_spacing: assert property (
      system_reset_pulse |=> (!system_reset_pulse) [*7]) else $error("reset pulses too close");
   // A restart held longer than the timeout pipeline keeps resets away.
   chk_restart_holds: assert property (
      counter_restart [*8] |-> !system_reset_pulse) else $error("reset despite restart");
   // Guard reset drops any pending interrupt.
   chk_reset_drops_irq: assert property (
      system_reset_pulse |-> ##2 !timeout_irq) else $error("irq survived guard reset");
   // Reads give one byte and flag unmapped words; errors only in access.
   chk_read_layout: assert property (
      acc && !pwrite |-> prdata[31:8] == 24'h0 && pslverr == !mapped)
      else $error("bad read layout");
   chk_idle_no_error: assert property (
      !acc |-> !pslverr) else $error("error outside access");
   // A settled programmed fuse reads as reset mode without interrupt.
   chk_fuse_forces: assert property (
      (!always_on_fuse_n) [*6] ##1
      (!always_on_fuse_n && acc && !pwrite && paddr == ADDR_CONTROL_STATUS)
      |-> prdata[BIT_RESET_ENABLE] && !prdata[BIT_IRQ_ENABLE]) else $error("fuse not forcing");
endmodule // wtc_timeout_guard_checker

bind wtc_timeout_guard wtc_timeout_guard_checker #(.OSC_DIV(OSC_DIV), .BASE_LOG2(BASE_LOG2))
   u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .counter_restart(counter_restart),
   .irq_vector_ack(irq_vector_ack), .cpu_global_irq_enable(cpu_global_irq_enable),
   .timeout_irq(timeout_irq), .system_reset_pulse(system_reset_pulse),
   .always_on_fuse_n(always_on_fuse_n));

// >>> dv/tb_top.sv
/* Self-checking bench for the timeout guard over APB.
   Assumes short counts (OSC_DIV 2, BASE_LOG2 2) and a 250 MHz pclk. */
`timescale 1ns/1ps
module tb_top;
   import wtc_pkg::*;
   localparam int          DIV = 2;
   localparam int          LOG = 2;
   localparam logic [11:0] CSR = ADDR_CONTROL_STATUS;
   localparam logic [11:0] CAU = ADDR_RESET_CAUSE;
   logic        pclk = 1'b0;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        counter_restart;
   logic        irq_vector_ack;
   logic        cpu_global_irq_enable;
   logic        timeout_irq;
   logic        system_reset_pulse;
   logic        always_on_fuse_n;
   logic [32:0] exp_q[$];
   int          miscompares = 0;
   int          checks = 0;
   int          seed = 98;
   int          n;
   int          lat;
   int          d;

   wtc_timeout_guard #(.OSC_DIV(DIV), .BASE_LOG2(LOG)) u_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .counter_restart(counter_restart),
      .irq_vector_ack(irq_vector_ack), .cpu_global_irq_enable(cpu_global_irq_enable),
      .timeout_irq(timeout_irq), .system_reset_pulse(system_reset_pulse),
      .always_on_fuse_n(always_on_fuse_n));

   // Free-running 4 ns clock.
   always #2 pclk = ~pclk;

   ////////////////////////////////////////////////////////////////////////////
   // Comparison, verdict and small helpers.
   task automatic check(input string name, input logic [32:0] e, input logic [32:0] g);
      checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic close_out();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Control/status byte from its fields.
   function automatic logic [7:0] cv(input logic ie, input logic re, input logic [3:0] c);
      return {1'b0, ie, c[3], 1'b0, re, c[2:0]};
   endfunction

   // Period in pclk cycles; reserved codes act as the longest one.
   function automatic int per(input int c);
      return DIV << (LOG + ((c > 9) ? 9 : c));
   endfunction

   // One APB transfer; upper write bits are random since only a byte is kept.
   task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] dt,
                      input logic [32:0] e);
      logic [31:0] rnd;
      int          k;
      rnd = $random(seed);
      k = 0;
      if (!wr)
         exp_q.push_back(e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {rnd[31:8], dt};
      @(posedge pclk);
      penable <= 1'b1;
      do
         begin
            @(posedge pclk);
            k++;
         end
      while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1)
      begin
         check("pready_bound", 33'h1, 33'h0);
         close_out();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic w(input logic [11:0] a, input logic [7:0] dt);
      apb(1'b1, a, dt, 33'h0);
   endtask

   task automatic r(input logic [11:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00, {25'h0, e});
   endtask

   // Protected change: unlock with reset enable, then the values.
   task automatic cfg(input logic [7:0] dt);
      w(CSR, 8'h18);
      w(CSR, dt);
   endtask

   task automatic ack();
      irq_vector_ack <= 1'b1;
      @(posedge pclk);
      irq_vector_ack <= 1'b0;
      @(posedge pclk);
   endtask

   // Bounded wait for the interrupt (0) or the reset pulse (1).
   task automatic wait_for(input logic sel, output int cnt);
      cnt = 0;
      do
         begin
            @(posedge pclk);
            cnt++;
         end
      while ((sel ? system_reset_pulse : timeout_irq) !== 1'b1 && cnt < 10000);
      if (cnt >= 10000)
      begin
         check("wait_bound", 33'h1, 33'h0);
         close_out();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Read monitor: every completed read is compared with the oldest note.
   always @(posedge pclk)
   begin
      if (presetn === 1'b1 && psel === 1'b1 && penable === 1'b1 && pready === 1'b1
          && pwrite === 1'b0 && exp_q.size() > 0)
         check("read_data", exp_q.pop_front(), {pslverr, prdata});
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence; the restart is held high outside the timed windows of each test, the stopped-mode window included.
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      counter_restart = 1'b1;
      irq_vector_ack = 1'b0;
      cpu_global_irq_enable = 1'b0;
      always_on_fuse_n = 1'b1;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      r(CSR, 8'h00);
      r(CAU, 8'h00);
      apb(1'b0, 12'h008, 8'h00, {1'b1, 32'h0});
      $display("test reset values done");
      // Flag rises while the CPU enable keeps the request low.
      cfg(cv(1'b1, 1'b0, 4'h0));
      counter_restart <= 1'b0;
      repeat (40) @(posedge pclk);
      counter_restart <= 1'b1;
      check("timeout_irq", 33'h0, timeout_irq);
      r(CSR, 8'hC0);
      cpu_global_irq_enable <= 1'b1;
      repeat (2) @(posedge pclk);
      check("timeout_irq", 33'h1, timeout_irq);
      ack();
      r(CSR, 8'h40);
      $display("test interrupt gating done");
      // Every period code, reserved ones included, measured against code 0.
      for (int c = 0; c < 16; c++)
      begin
         cfg(cv(1'b1, 1'b0, c[3:0]));
         counter_restart <= 1'b0;
         wait_for(1'b0, n);
         counter_restart <= 1'b1;
         if (c == 0)
            lat = n - per(0);
         d = n - per(c) - lat;
         check("timeout_period", 33'h1, {32'h0, d <= DIV && d >= -DIV});
         ack();
         r(CSR, cv(1'b1, 1'b0, c[3:0]));
      end
      $display("test period codes done");
      // Protected write arriving after the unlock window is refused.
      w(CSR, 8'h18);
      repeat (6) @(posedge pclk);
      w(CSR, 8'h00);
      r(CSR, 8'h2F);
      $display("test unlock window done");
      // Combined mode with the vector never taken ends in a guard reset.
      cfg(cv(1'b1, 1'b1, 4'h0));
      counter_restart <= 1'b0;
      wait_for(1'b0, n);
      wait_for(1'b1, n);
      counter_restart <= 1'b1;
      d = n - per(0);
      check("reset_delay", 33'h1, {32'h0, d <= DIV && d >= -DIV});
      r(CAU, 8'h08);
      r(CSR, 8'h08);
      cfg(8'h00);
      r(CSR, 8'h08);
      w(CAU, 8'h00);
      r(CAU, 8'h00);
      cfg(8'h00);
      r(CSR, 8'h00);
      $display("test guard reset done");
      // Combined mode with the vector taken drops to reset mode.
      cfg(cv(1'b1, 1'b1, 4'h0));
      counter_restart <= 1'b0;
      wait_for(1'b0, n);
      counter_restart <= 1'b1;
      ack();
      r(CSR, 8'h08);
      // Interrupt mode, flag cleared by writing one.
      cfg(cv(1'b1, 1'b0, 4'h0));
      counter_restart <= 1'b0;
      wait_for(1'b0, n);
      counter_restart <= 1'b1;
      cpu_global_irq_enable <= 1'b0;
      w(CSR, 8'hC0);
      r(CSR, 8'h40);
      // Stopped mode never expires.
      cfg(8'h00);
      counter_restart <= 1'b0;
      repeat (40) @(posedge pclk);
      counter_restart <= 1'b1;
      check("timeout_irq", 33'h0, timeout_irq);
      r(CAU, 8'h00);
      $display("test modes done");
      // Programmed fuse forces reset mode and ignores the interrupt enable.
      always_on_fuse_n <= 1'b0;
      repeat (6) @(posedge pclk);
      w(CSR, 8'h40);
      r(CSR, 8'h08);
      counter_restart <= 1'b0;
      wait_for(1'b1, n);
      counter_restart <= 1'b1;
      always_on_fuse_n <= 1'b1;
      r(CAU, 8'h08);
      w(CAU, 8'h00);
      $display("test fuse done");
      // A second power-on reset in mid-run.
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      r(CSR, 8'h00);
      r(CAU, 8'h00);
      $display("test second reset done");
      close_out();
   end
endmodule // tb_top
